// ==== logic/cis_map.svh ====
// Address map, field positions and reset values of the channel select and test registers
`ifndef CIS_MAP_SVH
`define CIS_MAP_SVH
// ==========================================
// Per-channel offsets (channel n adds n times the stride)
`define CIS_CH_STRIDE 8'h10
`define CIS_SEL_OFS 8'h01
`define CIS_SLEWRD_OFS 8'h01
`define CIS_PHASE_OFS 8'h06
`define CIS_CODESEL_OFS 8'h0d
`define CIS_SLEWLD_OFS 8'h0e
`define CIS_CNTL_OFS 8'h0f
// ==========================================
// Broadcast offsets
`define CIS_SEL_ALL 8'h71
`define CIS_PHASE_ALL 8'h76
// ==========================================
// 20 ms epoch registers
`define CIS_EPOCH_BASE 8'ha3
`define CIS_EPOCH_STRIDE 8'h04
`define CIS_EPOCH_ALL 8'hbf
// ==========================================
// Field positions
`define CIS_TEST_BIT 6
`define CIS_EPOCH_MSB 5
`define CIS_MODE_BIT 0
`define CIS_RB_SRC_BIT 13
`define CIS_SEL_MSB 3
`define CIS_PHASE_MSB 10
`define CIS_SLEW_MSB 10
`define CIS_CODE_MSB 7
// ==========================================
// Encodings and reset values
`define CIS_SEL_SELFTEST 4'ha
`define CIS_SEL_GROUND 4'hb
`define CIS_SEL_PORTS 4'ha
`define CIS_CODE_DUP 8'h25
`define CIS_CODE_CANON 8'h22
`define CIS_SEL_RST 4'hb
`define CIS_CNTL_RST 16'h0000
`define CIS_CODE_RST 8'h00
`define CIS_EPOCH_RST 6'h00
`define CIS_SLEW_RST 11'h000
`define CIS_NUM_CH 6
`endif

// ==== logic/cis_pkg.sv ====
// Types shared by the channel select and test register files
package cis_pkg;
   // ==========================================
   // Microprocessor bus request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } cis_bus_t;
   // ==========================================
   // Per-channel events from the correlator core
   typedef struct packed {
      logic osc_msb;
      logic dump;
      logic tick;
      logic slew_step;
   } cis_chan_in_t;
   // ==========================================
   // Per-channel controls toward the correlator core
   typedef struct packed {
      logic sig_sign;
      logic sig_mag;
      logic phase_load;
      logic [10:0] phase_val;
      logic epoch_load;
      logic [5:0] epoch_val;
      logic test_mode;
      logic preset_mode;
      logic [7:0] code_sel;
      logic slew_enabled;
   } cis_chan_out_t;
endpackage : cis_pkg

// ==== logic/cis_regs.sv ====
// Six-channel input select, code phase test preload and slew read-back registers
// Contract
// - Input select writes accepted anytime; 4-bit field picks port 0-9, self-test, ground.
// - Self-test selection feeds the channel with internal self-test sign and magnitude.
// - Phase preload accepted only with test mode high and oscillator MSB low.
// - Accepted preload loads the 11-bit code phase counter from the data bus.
// - Broadcast preload acts only on channels whose test mode bit is set.
// - Slew read-back allowed anytime; bits 10-0 show the live slew count.
// - Read-back bit 12 mirrors control bit 13; bits 15-13 undefined.
// - Read-back bit 11 is 0 at zero count, 1 if nonzero or disabled.
// - Update mode enables slew counting after load and a later dump.
// - Preset mode loads and enables slew on tick if epoch was written.
// - Code selections 34 and 37 use identical generator seeds.
// - Test mode is epoch bit 6, cleared by reset, normal when low.
// - Epoch writes apply immediately in update mode, after next tick in preset.
`timescale 1ns/1ps
`default_nettype none
`include "cis_map.svh"
module cis_regs (
   input wire logic clk, // System clock
   input wire logic rst, // Synchronous reset, high
   input wire cis_pkg::cis_bus_t bus, // Microprocessor access
   output logic [15:0] rdata_q, // Read data
   input wire logic [9:0] port_sign, // Input port sign pins
   input wire logic [9:0] port_mag, // Input port magnitude pins
   input wire logic selftest_sign_out, // Internal self-test sign
   input wire logic selftest_magnitude_out, // Internal self-test magnitude
   input wire cis_pkg::cis_chan_in_t [5:0] ch_in, // Core events per channel
   output var cis_pkg::cis_chan_out_t [5:0] ch_out // Controls per channel
);
   import cis_pkg::*;

   // ==========================================
   // Pin synchronisers
   logic [9:0] sign_m_q, sign_s_q, mag_m_q, mag_s_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         sign_m_q <= 10'h000;
         sign_s_q <= 10'h000;
         mag_m_q <= 10'h000;
         mag_s_q <= 10'h000;
      end else begin
         sign_m_q <= port_sign;
         sign_s_q <= sign_m_q;
         mag_m_q <= port_mag;
         mag_s_q <= mag_m_q;
      end
   end

   logic [15:0] slew_word [`CIS_NUM_CH];
   logic [5:0] rd_hit;

   // ==========================================
   // Channels
   genvar g;
   generate
      for (g = 0; g < `CIS_NUM_CH; g++) begin : gch
         localparam logic [7:0] BASE = 8'(g * `CIS_CH_STRIDE);
         localparam logic [7:0] EPOCH_ADDR = 8'(`CIS_EPOCH_BASE + g * `CIS_EPOCH_STRIDE);
         logic [3:0] sel_q, sel_d;
         logic [15:0] cntl_q, cntl_d;
         logic [7:0] code_q, code_d;
         logic test_q, test_d;
         logic sign_q, sign_d, mag_q, mag_d;
         logic phase_load_q, phase_load_d;
         logic [10:0] phase_val_q, phase_val_d;
         logic own_sel, own_phase, own_slew, own_cntl, own_code, own_epoch;
         logic phase_ok;
         logic [10:0] count;
         logic enabled;
         logic epoch_load;
         logic [5:0] epoch_out;

         assign own_sel = bus.wr && (bus.addr == BASE + `CIS_SEL_OFS
                          || bus.addr == `CIS_SEL_ALL);
         assign own_phase = bus.wr && (bus.addr == BASE + `CIS_PHASE_OFS
                            || bus.addr == `CIS_PHASE_ALL);
         assign own_slew = bus.wr && bus.addr == BASE + `CIS_SLEWLD_OFS;
         assign own_cntl = bus.wr && bus.addr == BASE + `CIS_CNTL_OFS;
         assign own_code = bus.wr && bus.addr == BASE + `CIS_CODESEL_OFS;
         assign own_epoch = bus.wr && (bus.addr == EPOCH_ADDR
                            || bus.addr == `CIS_EPOCH_ALL);
         assign phase_ok = test_q && !ch_in[g].osc_msb;
         assign rd_hit[g] = bus.addr == BASE + `CIS_SLEWRD_OFS;

         always_comb begin
            sel_d = sel_q;
            cntl_d = cntl_q;
            code_d = code_q;
            test_d = test_q;
            phase_load_d = 1'b0;
            phase_val_d = phase_val_q;
            if (own_sel) begin
               sel_d = bus.wdata[`CIS_SEL_MSB:0];
            end
            if (own_cntl) begin
               cntl_d = bus.wdata;
            end
            if (own_code) begin
               code_d = bus.wdata[`CIS_CODE_MSB:0];
            end
            if (own_epoch) begin
               // The test bit is a static control, so it acts at once in both modes
               test_d = bus.wdata[`CIS_TEST_BIT];
            end
            if (own_phase && phase_ok) begin
               phase_load_d = 1'b1;
               phase_val_d = bus.wdata[`CIS_PHASE_MSB:0];
            end
            // Codes 12 to 15 are undefined and treated as ground
            if (sel_q < `CIS_SEL_PORTS) begin
               sign_d = sign_s_q[sel_q];
               mag_d = mag_s_q[sel_q];
            end else if (sel_q == `CIS_SEL_SELFTEST) begin
               sign_d = selftest_sign_out;
               mag_d = selftest_magnitude_out;
            end else begin
               sign_d = 1'b0;
               mag_d = 1'b0;
            end
         end

         always_ff @(posedge clk) begin
            if (rst) begin
               sel_q <= `CIS_SEL_RST;
               cntl_q <= `CIS_CNTL_RST;
               code_q <= `CIS_CODE_RST;
               test_q <= 1'b0;
               sign_q <= 1'b0;
               mag_q <= 1'b0;
               phase_load_q <= 1'b0;
               phase_val_q <= `CIS_SLEW_RST;
            end else begin
               sel_q <= sel_d;
               cntl_q <= cntl_d;
               code_q <= code_d;
               test_q <= test_d;
               sign_q <= sign_d;
               mag_q <= mag_d;
               phase_load_q <= phase_load_d;
               phase_val_q <= phase_val_d;
            end
         end

         cis_slew u_slew (
            .clk(clk),
            .rst(rst),
            .preset_mode(cntl_q[`CIS_MODE_BIT]),
            .slew_wr(own_slew),
            .slew_val(bus.wdata[`CIS_SLEW_MSB:0]),
            .epoch_wr(own_epoch),
            .epoch_val(bus.wdata[`CIS_EPOCH_MSB:0]),
            .dump(ch_in[g].dump),
            .tick(ch_in[g].tick),
            .step(ch_in[g].slew_step),
            .count_q(count),
            .enabled_q(enabled),
            .epoch_load_q(epoch_load),
            .epoch_out_q(epoch_out)
         );

         // Live count, not frozen during the read
         assign slew_word[g] = {3'h0, cntl_q[`CIS_RB_SRC_BIT],
                                !(enabled && count == `CIS_SLEW_RST),
                                count};

         assign ch_out[g].sig_sign = sign_q;
         assign ch_out[g].sig_mag = mag_q;
         assign ch_out[g].phase_load = phase_load_q;
         assign ch_out[g].phase_val = phase_val_q;
         assign ch_out[g].epoch_load = epoch_load;
         assign ch_out[g].epoch_val = epoch_out;
         assign ch_out[g].test_mode = test_q;
         assign ch_out[g].preset_mode = cntl_q[`CIS_MODE_BIT];
         // One seed table entry serves both duplicated codes
         assign ch_out[g].code_sel = (code_q == `CIS_CODE_DUP) ? `CIS_CODE_CANON
                                     : code_q;
         assign ch_out[g].slew_enabled = enabled;
      end
   endgenerate

   // ==========================================
   // Read-back
   logic [15:0] rdata_d;
   always_comb begin
      rdata_d = rdata_q;
      if (bus.rd) begin
         rdata_d = 16'h0000;
         for (int i = 0; i < `CIS_NUM_CH; i++) begin
            if (rd_hit[i]) begin
               rdata_d = slew_word[i];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end
endmodule : cis_regs
`default_nettype wire

// ==== logic/cis_slew.sv ====
// Code slew counter with its enable sequencing and the 20 ms epoch load timing
`timescale 1ns/1ps
`default_nettype none
`include "cis_map.svh"
module cis_slew (
   input wire logic clk, // System clock
   input wire logic rst, // Synchronous reset, high
   input wire logic preset_mode, // Channel in preset mode
   input wire logic slew_wr, // Slew register write
   input wire logic [10:0] slew_val, // Slew value written
   input wire logic epoch_wr, // 20 ms epoch register write
   input wire logic [5:0] epoch_val, // Epoch value written
   input wire logic dump, // Accumulation dump event
   input wire logic tick, // Timing tick event
   input wire logic step, // Slew count step
   output logic [10:0] count_q, // Live slew count
   output logic enabled_q, // Counter enabled to count
   output logic epoch_load_q, // Epoch counter load pulse
   output logic [5:0] epoch_out_q // Epoch counter load value
);
   import cis_pkg::*;
   logic [10:0] count_d;
   logic enabled_d;
   logic loaded_q, loaded_d;
   logic [10:0] staged_q, staged_d;
   logic epoch_pend_q, epoch_pend_d;
   logic [5:0] epoch_stage_q, epoch_stage_d;
   logic epoch_load_d;
   logic [5:0] epoch_out_d;

   // ==========================================
   // Next state
   always_comb begin
      count_d = count_q;
      enabled_d = enabled_q;
      loaded_d = loaded_q;
      staged_d = staged_q;
      epoch_pend_d = epoch_pend_q;
      epoch_stage_d = epoch_stage_q;
      epoch_load_d = 1'b0;
      epoch_out_d = epoch_out_q;
      if (enabled_q && step && count_q != `CIS_SLEW_RST) begin
         count_d = count_q - 11'h001;
      end
      if (epoch_wr) begin
         if (preset_mode) begin
            epoch_pend_d = 1'b1;
            epoch_stage_d = epoch_val;
         end else begin
            epoch_load_d = 1'b1;
            epoch_out_d = epoch_val;
         end
      end
      if (preset_mode && tick && epoch_pend_q) begin
         epoch_load_d = 1'b1;
         epoch_out_d = epoch_stage_q;
         epoch_pend_d = epoch_wr;
         count_d = staged_q;
         enabled_d = 1'b1;
         loaded_d = 1'b0;
      end
      if (!preset_mode && dump && loaded_q) begin
         enabled_d = 1'b1;
         loaded_d = 1'b0;
      end
      if (slew_wr) begin
         // Preset mode defers the count to the tick; update mode loads it now
         staged_d = slew_val;
         if (!preset_mode) begin
            count_d = slew_val;
            loaded_d = 1'b1;
         end
         enabled_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         count_q <= `CIS_SLEW_RST;
         enabled_q <= 1'b0;
         loaded_q <= 1'b0;
         staged_q <= `CIS_SLEW_RST;
         epoch_pend_q <= 1'b0;
         epoch_stage_q <= `CIS_EPOCH_RST;
         epoch_load_q <= 1'b0;
         epoch_out_q <= `CIS_EPOCH_RST;
      end else begin
         count_q <= count_d;
         enabled_q <= enabled_d;
         loaded_q <= loaded_d;
         staged_q <= staged_d;
         epoch_pend_q <= epoch_pend_d;
         epoch_stage_q <= epoch_stage_d;
         epoch_load_q <= epoch_load_d;
         epoch_out_q <= epoch_out_d;
      end
   end
endmodule : cis_slew
`default_nettype wire

// ==== sim/cis_cpu.sv ====
// Microprocessor model driving the register bus
`timescale 1ns/1ps
`default_nettype none
module cis_cpu (
   input wire logic clk, // System clock
   output var cis_pkg::cis_bus_t bus // Bus requests
);
   import cis_pkg::*;
   initial bus = '0;
   // Idle address and data are inverted so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      #1;
      bus = '{1'b1, 1'b0, a, d};
      @(posedge clk);
      #1;
      bus = '{1'b0, 1'b0, ~a, ~d};
   endtask : wr
   // Read word is taken as is; the count may move under the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      #1;
      bus = '{1'b0, 1'b1, a, 16'h0000};
      @(posedge clk);
      #1;
      bus = '{1'b0, 1'b0, ~a, 16'hffff};
   endtask : rd
endmodule : cis_cpu
`default_nettype wire

// ==== sim/cis_regs_sva.sv ====
// Assertion checker for the channel select and test registers
`timescale 1ns/1ps
`default_nettype none
module cis_regs_chk (
   input wire logic clk, // System clock
   input wire logic rst, // Reset
   input wire cis_pkg::cis_bus_t bus, // Bus access
   input wire logic [15:0] rdata_q, // Read data
   input wire logic [9:0] port_sign, // Port signs
   input wire logic [9:0] port_mag, // Port magnitudes
   input wire logic selftest_sign_out, // Self-test sign
   input wire logic selftest_magnitude_out, // Self-test magnitude
   input wire cis_pkg::cis_chan_in_t [5:0] ch_in, // Core events
   input wire cis_pkg::cis_chan_out_t [5:0] ch_out // Channel controls
);
   import cis_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ======
   // Phase preload
   property p_ph_take;
      bus.wr && bus.addr == 8'h06 && ch_out[0].test_mode && !ch_in[0].osc_msb
      |=> ch_out[0].phase_load && ch_out[0].phase_val == $past(bus.wdata[10:0]);
   endproperty
   a_ph_take: assert property (p_ph_take) else $error("preload missed");
   property p_ph_refuse;
      bus.wr && bus.addr == 8'h06 && (!ch_out[0].test_mode || ch_in[0].osc_msb)
      |=> !ch_out[0].phase_load;
   endproperty
   a_ph_refuse: assert property (p_ph_refuse) else $error("preload not refused");
   property p_bc_skip;
      bus.wr && bus.addr == 8'h76 && !ch_out[1].test_mode |=> !ch_out[1].phase_load;
   endproperty
   a_bc_skip: assert property (p_bc_skip) else $error("broadcast hit idle channel");
   // ======
   // Epoch and test bit
   property p_test_bit;
      bus.wr && bus.addr == 8'ha3 |=> ch_out[0].test_mode == $past(bus.wdata[6]);
   endproperty
   a_test_bit: assert property (p_test_bit) else $error("test bit wrong");
   property p_ep_upd;
      bus.wr && bus.addr == 8'ha3 && !ch_out[0].preset_mode
      |=> ch_out[0].epoch_load && ch_out[0].epoch_val == $past(bus.wdata[5:0]);
   endproperty
   a_ep_upd: assert property (p_ep_upd) else $error("epoch not immediate");
   property p_ep_wait;
      bus.wr && bus.addr == 8'ha7 && ch_out[1].preset_mode && !ch_in[1].tick
      |=> !ch_out[1].epoch_load;
   endproperty
   a_ep_wait: assert property (p_ep_wait) else $error("epoch did not wait");
   // ======
   // Slew counter
   property p_rb;
      bus.rd && bus.addr == 8'h01
      |=> rdata_q[11] == !($past(ch_out[0].slew_enabled) && rdata_q[10:0] == 11'h000);
   endproperty
   a_rb: assert property (p_rb) else $error("zero flag wrong");
   property p_slew_off;
      bus.wr && bus.addr == 8'h0e && !ch_out[0].preset_mode |=> !ch_out[0].slew_enabled;
   endproperty
   a_slew_off: assert property (p_slew_off) else $error("enabled on load");
   property p_en_upd;
      $rose(ch_out[0].slew_enabled) && !ch_out[0].preset_mode |-> $past(ch_in[0].dump);
   endproperty
   a_en_upd: assert property (p_en_upd) else $error("enable without dump");
   property p_en_pre;
      $rose(ch_out[1].slew_enabled) && ch_out[1].preset_mode
      |-> $past(ch_in[1].tick) && ch_out[1].epoch_load;
   endproperty
   a_en_pre: assert property (p_en_pre) else $error("enable without tick");
endmodule : cis_regs_chk
bind cis_regs cis_regs_chk u_chk (.clk(clk), .rst(rst), .bus(bus), .rdata_q(rdata_q),
   .port_sign(port_sign), .port_mag(port_mag), .selftest_sign_out(selftest_sign_out),
   .selftest_magnitude_out(selftest_magnitude_out), .ch_in(ch_in), .ch_out(ch_out));
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for the channel select and test registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import cis_pkg::*;
   logic clk, rst, sts, stm, rd_q;
   logic [9:0] ps, pm;
   cis_bus_t bus;
   cis_chan_in_t [5:0] ci;
   cis_chan_out_t [5:0] dout;
   logic [15:0] rdata_q;
   logic [15:0] exp_rd[$];
   logic [10:0] exp_ph[6][$];
   int err_count = 0;
   int samples_checked = 0;
   int n;
   logic [10:0] v;
   logic [1:0] e;
   logic [7:0] cs[3];
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   cis_cpu cpu (.clk(clk), .bus(bus));
   cis_regs DUT (.clk(clk), .rst(rst), .bus(bus), .rdata_q(rdata_q), .port_sign(ps),
      .port_mag(pm), .selftest_sign_out(sts), .selftest_magnitude_out(stm), .ch_in(ci),
      .ch_out(dout));
   // ======
   // Helpers
   task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
      samples_checked++;
      if (got !== ex) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   task automatic ev(input int g, input int b);
      @(posedge clk);
      #1;
      ci[g][b] = 1'b1;
      @(posedge clk);
      #1;
      ci[g][b] = 1'b0;
   endtask : ev
   task automatic rdx(input logic [7:0] a, input logic [15:0] ex);
      exp_rd.push_back(ex);
      cpu.rd(a);
   endtask : rdx
   task automatic results();
      err_count += exp_rd.size() + exp_ph[0].size() + exp_ph[2].size();
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : results
   // ======
   // Monitor: an unexpected pulse meets an empty queue and fails
   always @(posedge clk) rd_q <= bus.rd;
   always @(negedge clk) begin
      logic [10:0] pv;
      if (rst === 1'b0) begin
         if (rd_q === 1'b1) begin
            chk("read", exp_rd.size() > 0 ? exp_rd.pop_front() : 16'hxxxx, rdata_q);
         end
         for (int g = 0; g < 6; g++) begin
            if (dout[g].phase_load !== 1'b0) begin
               pv = exp_ph[g].size() > 0 ? exp_ph[g].pop_front() : 11'hxxx;
               chk("phase", 16'(pv), 16'(dout[g].phase_val));
            end
         end
      end
   end
   // ======
   // Tests
   initial begin
      rst = 1'b1;
      ci = '0;
      {ps, pm, sts, stm} = '0;
      n = $urandom(76);
      repeat (12) @(posedge clk);
      #1;
      rst = 1'b0;
      rdx(8'h01, 16'h0800);
      rdx(8'h02, 16'h0000);
      $display("test reset done");
      // Codes 12 to 15 are undefined and must give ground like code 11
      for (int c = 0; c < 16; c++) begin
         {ps, pm, sts, stm} = 22'($urandom);
         cpu.wr(c[0] ? 8'h01 : 8'h71, {12'($urandom), 4'(c)});
         repeat (4) @(posedge clk);
         #1;
         e = c < 10 ? {ps[c], pm[c]} : (c == 10 ? {sts, stm} : 2'b00);
         chk("select", 16'(e), 16'({dout[0].sig_sign, dout[0].sig_mag}));
         if (!c[0]) chk("select all", 16'(e), 16'({dout[5].sig_sign, dout[5].sig_mag}));
      end
      $display("test select done");
      cs = '{8'h25, 8'h22, 8'($urandom)};
      foreach (cs[i]) begin
         cpu.wr(8'h0d, 16'(cs[i]));
         repeat (2) @(posedge clk);
         #1;
         chk("code", 16'(cs[i] == 8'h25 ? 8'h22 : cs[i]), 16'(dout[0].code_sel));
      end
      $display("test code done");
      cpu.wr(8'ha3, 16'h0040);
      cpu.wr(8'hab, 16'h0040);
      v = 11'($urandom);
      exp_ph[0].push_back(v);
      cpu.wr(8'h06, 16'(v));
      ci[0].osc_msb = 1'b1;
      cpu.wr(8'h06, 16'h07ff);
      ci[0].osc_msb = 1'b0;
      v = 11'($urandom);
      exp_ph[0].push_back(v);
      exp_ph[2].push_back(v);
      cpu.wr(8'h76, {5'h1f, v});
      cpu.wr(8'ha3, 16'h0000);
      cpu.wr(8'h06, 16'h0123);
      $display("test phase done");
      // Mid-run reset must clear the test bit left set on channel 2
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      rst = 1'b0;
      cpu.wr(8'h76, 16'h0155);
      rdx(8'h01, 16'h0800);
      $display("test second reset done");
      n = $urandom_range(6, 1);
      cpu.wr(8'h0f, 16'h2000);
      cpu.wr(8'h0e, 16'(n));
      ev(0, 0);
      rdx(8'h01, 16'h1800 | 16'(n));
      ev(0, 2);
      repeat (n - 1) ev(0, 0);
      rdx(8'h01, 16'h1801);
      ev(0, 0);
      rdx(8'h01, 16'h1000);
      $display("test update done");
      cpu.wr(8'h1f, 16'h0001);
      cpu.wr(8'h1e, 16'h0002);
      ev(1, 1);
      rdx(8'h11, 16'h0800);
      cpu.wr(8'ha7, 16'h0005);
      ev(1, 1);
      rdx(8'h11, 16'h0802);
      repeat (3) @(posedge clk);
      $display("test preset done");
      results();
   end
endmodule : tb_top
`default_nettype wire
